//--- hdl/report_mem.sv
// Report buffer holding one interrupt report from the infrared side.
// Single clock; read data is registered, one cycle after the address.
`timescale 1ns/100ps
module report_mem #(
	parameter int W = 8,
	parameter int AW = 4
) (
	input wire logic i_ref_clk,
	input wire logic i_wr_en,
	input wire logic [AW-1:0] i_wr_addr,
	input wire logic [W-1:0] i_wr_data,
	input wire logic [AW-1:0] i_rd_addr,
	output logic [W-1:0] o_rd_data
);
	logic [W-1:0] mem [2**AW];

	always_ff @(posedge i_ref_clk) begin
		if (i_wr_en) begin
			mem[i_wr_addr] <= i_wr_data;
		end
		o_rd_data <= mem[i_rd_addr];
	end
endmodule

//--- hdl/usb_dongle_endpoint_config.sv
// Function-side USB transaction engine of the infrared dongle.
// Packets arrive decoded from a serial engine on the same clock.
//
// Contract
// R1 - handle tokens, data packets and handshakes
// R2 - EP0 control; EP1, EP3, EP5 interrupt IN
// R3 - remote wake only if standby and self-powered
// R4 - suspended plus infrared data signals resume
// R5 - configuration 1 selects emulation mode
// R6 - configuration 2 selects bridge mode
// R7 - emulation keyboard data on endpoint 1
// R8 - emulation mouse data on endpoint 5
// R9 - bridge: peripherals share one endpoint
// R10 - control on EP0, peripheral data EP1
// R11 - control begins with setup; control, interrupt only
// R12 - get configuration returns current value
// R13 - set configuration switches operating mode
// R14 - remap at once, drop undefined endpoint data
`timescale 1ns/100ps
module usb_dongle_endpoint_config #(
	parameter int unsigned RESUME_CYCLES = usb_dongle_pkg::RESUME_CYC,
	parameter int AW = usb_dongle_pkg::REPORT_AW
) (
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire usb_dongle_pkg::token_type i_tok,
	input wire usb_dongle_pkg::rx_data_type i_data,
	input wire logic i_tx_ready,
	output usb_dongle_pkg::tx_type o_tx,
	input wire usb_dongle_pkg::ir_wr_type i_ir_wr,
	input wire usb_dongle_pkg::ir_commit_type i_ir_commit,
	output logic o_ir_ready,
	input wire logic i_suspend,
	input wire logic i_self_pwr,
	output logic o_remote_wake_ok,
	output logic o_resume,
	output logic [1:0] o_config
);
	typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_OUT, ST_HS, ST_FETCH,
		ST_LOAD, ST_SEND, ST_WAIT_ACK} state_type;
	typedef enum logic [2:0] {CS_IDLE, CS_DATA_IN, CS_STATUS_IN,
		CS_STATUS_OUT, CS_STALL} cstage_type;

	state_type state_q;
	cstage_type cstage_q;
	usb_dongle_pkg::tx_type tx_q;
	usb_dongle_pkg::chan_type pchan_q;
	logic [1:0] cfg_q;
	logic [6:0] addr_q, new_addr_q;
	logic addr_pend_q, rwu_en_q, pend_q, src_int_q;
	logic [7:0] periph_q;
	logic [AW:0] plen_q;
	logic [AW-1:0] idx_q;
	logic [7:0] tog_q;
	logic [3:0] cur_ep_q;
	logic [7:0] rd_data;
	logic pwr_meta_q, pwr_q;
	logic [31:0] res_cnt_q;
	logic tok_me, setup_take, is_get_cfg, is_set_cfg, is_set_rwu, is_clr_rwu;
	logic is_set_addr, req_ok, int_hit, ep_defined, ack_in, ack_ctrl;
	logic ack_int, rwu_ok, wake, tag_q;
	logic [3:0] map_ep;

	// Pin is asynchronous to the reference clock
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			pwr_meta_q <= 1'b0;
			pwr_q <= 1'b0;
		end else begin
			pwr_meta_q <= i_self_pwr;
			pwr_q <= pwr_meta_q;
		end
	end

	assign map_ep = usb_dongle_pkg::ep_of(pchan_q, cfg_q);
	assign tok_me = i_tok.valid && i_tok.addr == addr_q;
	assign int_hit = tok_me && i_tok.pid == usb_dongle_pkg::PID_IN &&
		pend_q && i_tok.ep != usb_dongle_pkg::EP_CTRL &&
		i_tok.ep == map_ep; // R2 R14
	assign ep_defined = (cfg_q == usb_dongle_pkg::CFG_EMUL &&
		(i_tok.ep == usb_dongle_pkg::EP_KEY ||
		i_tok.ep == usb_dongle_pkg::EP_MOUSE)) ||
		(cfg_q == usb_dongle_pkg::CFG_BRIDGE &&
		(i_tok.ep == usb_dongle_pkg::EP_KEY ||
		i_tok.ep == usb_dongle_pkg::EP_AUX)); // R2 R7 R8

	// Only DATA0 with good check closes a setup stage
	assign setup_take = state_q == ST_SETUP && i_data.valid &&
		i_data.pid == usb_dongle_pkg::PID_DATA0 && i_data.crc_ok; // R11
	assign is_get_cfg = i_data.req_type == usb_dongle_pkg::RT_DEV_IN &&
		i_data.request == usb_dongle_pkg::REQ_GET_CONFIG;
	assign is_set_cfg = i_data.req_type == usb_dongle_pkg::RT_DEV_OUT &&
		i_data.request == usb_dongle_pkg::REQ_SET_CONFIG &&
		i_data.value[7:2] == 6'h00 && i_data.value[1:0] != 2'h3;
	assign is_set_rwu = i_data.req_type == usb_dongle_pkg::RT_DEV_OUT &&
		i_data.request == usb_dongle_pkg::REQ_SET_FEATURE &&
		i_data.value == usb_dongle_pkg::FEAT_RWU;
	assign is_clr_rwu = i_data.req_type == usb_dongle_pkg::RT_DEV_OUT &&
		i_data.request == usb_dongle_pkg::REQ_CLR_FEATURE &&
		i_data.value == usb_dongle_pkg::FEAT_RWU;
	assign is_set_addr = i_data.req_type == usb_dongle_pkg::RT_DEV_OUT &&
		i_data.request == usb_dongle_pkg::REQ_SET_ADDRESS &&
		i_data.value[7] == 1'b0;
	assign req_ok = is_get_cfg || is_set_cfg || is_set_rwu || is_clr_rwu ||
		is_set_addr;
	assign ack_in = state_q == ST_WAIT_ACK && i_tok.valid &&
		i_tok.pid == usb_dongle_pkg::PID_ACK; // R1
	assign ack_ctrl = ack_in && !src_int_q;
	assign ack_int = ack_in && src_int_q;
	assign rwu_ok = rwu_en_q && pwr_q && i_suspend; // R3
	assign wake = rwu_ok && i_ir_commit.valid && o_ir_ready; // R4

	report_mem #(.W(8), .AW(AW)) u_mem (
		.i_ref_clk(i_ref_clk),
		.i_wr_en(i_ir_wr.valid && !pend_q),
		.i_wr_addr(i_ir_wr.addr),
		.i_wr_data(i_ir_wr.data),
		.i_rd_addr(idx_q),
		.o_rd_data(rd_data)
	);

	// Transaction sequencer
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			state_q <= ST_IDLE;
			tx_q <= '0;
			idx_q <= '0;
			src_int_q <= 1'b0;
			cur_ep_q <= 4'h0;
			tag_q <= 1'b0;
		end else begin
			case (state_q)
			ST_IDLE: begin
				if (tok_me && i_tok.ep == usb_dongle_pkg::EP_CTRL) begin
					src_int_q <= 1'b0;
					cur_ep_q <= usb_dongle_pkg::EP_CTRL;
					if (i_tok.pid == usb_dongle_pkg::PID_SETUP) begin
						state_q <= ST_SETUP; // R11
					end else if (i_tok.pid == usb_dongle_pkg::PID_OUT) begin
						state_q <= ST_OUT;
					end else if (i_tok.pid == usb_dongle_pkg::PID_IN) begin
						if (cstage_q == CS_DATA_IN) begin
							tx_q <= '{1'b1, usb_dongle_pkg::PID_DATA1, 1'b1,
								{6'h00, cfg_q}, 1'b1}; // R12
							state_q <= ST_SEND;
						end else if (cstage_q == CS_STATUS_IN) begin
							tx_q <= '{1'b1, usb_dongle_pkg::PID_DATA1, 1'b0,
								8'h00, 1'b1};
							state_q <= ST_SEND;
						end else if (cstage_q == CS_STALL) begin
							tx_q <= '{1'b1, usb_dongle_pkg::PID_STALL, 1'b0,
								8'h00, 1'b1};
							state_q <= ST_HS;
						end else begin
							tx_q <= '{1'b1, usb_dongle_pkg::PID_NAK, 1'b0,
								8'h00, 1'b1};
							state_q <= ST_HS;
						end
					end
				end else if (int_hit) begin
					src_int_q <= 1'b1;
					cur_ep_q <= i_tok.ep;
					tag_q <= pchan_q == usb_dongle_pkg::CH_BRIDGE; // R9
					idx_q <= '0;
					tx_q.pid <= tog_q[i_tok.ep[2:0]] ?
						usb_dongle_pkg::PID_DATA1 : usb_dongle_pkg::PID_DATA0;
					if (pchan_q == usb_dongle_pkg::CH_BRIDGE) begin
						// Peripheral tag leads so the host can demultiplex
						tx_q.valid <= 1'b1;
						tx_q.has_data <= 1'b1;
						tx_q.data <= periph_q; // R9 R10
						tx_q.last <= plen_q == '0;
						state_q <= ST_SEND;
					end else if (plen_q == '0) begin
						tx_q.valid <= 1'b1;
						tx_q.has_data <= 1'b0;
						tx_q.last <= 1'b1;
						state_q <= ST_SEND;
					end else begin
						state_q <= ST_FETCH;
					end
				end else if (tok_me && i_tok.pid == usb_dongle_pkg::PID_IN &&
					ep_defined) begin
					tx_q <= '{1'b1, usb_dongle_pkg::PID_NAK, 1'b0, 8'h00, 1'b1};
					state_q <= ST_HS; // R1
				end
			end
			ST_SETUP: begin
				if (setup_take) begin
					tx_q <= '{1'b1, usb_dongle_pkg::PID_ACK, 1'b0, 8'h00, 1'b1};
					state_q <= ST_HS;
				end else if (i_data.valid || i_tok.valid) begin
					state_q <= ST_IDLE;
				end
			end
			ST_OUT: begin
				if (i_data.valid && i_data.crc_ok) begin
					tx_q <= '{1'b1, cstage_q == CS_STALL ?
						usb_dongle_pkg::PID_STALL : usb_dongle_pkg::PID_ACK,
						1'b0, 8'h00, 1'b1};
					state_q <= ST_HS;
				end else if (i_data.valid || i_tok.valid) begin
					state_q <= ST_IDLE;
				end
			end
			ST_HS: begin
				if (i_tx_ready) begin
					tx_q.valid <= 1'b0;
					state_q <= ST_IDLE;
				end
			end
			ST_FETCH: state_q <= ST_LOAD;
			ST_LOAD: begin
				tx_q.valid <= 1'b1;
				tx_q.has_data <= 1'b1;
				tx_q.data <= rd_data;
				tx_q.last <= ({1'b0, idx_q} + 5'h01) == plen_q;
				state_q <= ST_SEND;
			end
			ST_SEND: begin
				if (i_tx_ready) begin
					tx_q.valid <= 1'b0;
					if (tx_q.last) begin
						state_q <= ST_WAIT_ACK;
					end else begin
						// Tag beat reads no buffer byte; data may equal it
						if (!tag_q) begin
							idx_q <= idx_q + 1'b1;
						end
						tag_q <= 1'b0;
						state_q <= ST_FETCH;
					end
				end
			end
			ST_WAIT_ACK: begin
				// A new token means the ACK was lost; data stays for retry
				if (i_tok.valid) begin
					state_q <= ST_IDLE;
				end
			end
			default: state_q <= ST_IDLE;
			endcase
		end
	end

	// Control stage, address, wake enable and configuration
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			cstage_q <= CS_IDLE;
			cfg_q <= usb_dongle_pkg::CFG_NONE;
			rwu_en_q <= 1'b0;
			addr_q <= usb_dongle_pkg::ADDR_RESET;
			new_addr_q <= usb_dongle_pkg::ADDR_RESET;
			addr_pend_q <= 1'b0;
		end else if (setup_take) begin
			addr_pend_q <= 1'b0;
			if (!req_ok) begin
				cstage_q <= CS_STALL; // R11
			end else if (is_get_cfg) begin
				cstage_q <= CS_DATA_IN;
			end else begin
				cstage_q <= CS_STATUS_IN;
			end
			if (is_set_cfg) begin
				cfg_q <= i_data.value[1:0]; // R5 R6 R13
			end
			if (is_set_rwu) begin
				rwu_en_q <= 1'b1;
			end else if (is_clr_rwu) begin
				rwu_en_q <= 1'b0;
			end
			if (is_set_addr) begin
				new_addr_q <= i_data.value[6:0];
				addr_pend_q <= 1'b1;
			end
		end else if (ack_ctrl && cstage_q == CS_DATA_IN) begin
			cstage_q <= CS_STATUS_OUT;
		end else if (ack_ctrl && cstage_q == CS_STATUS_IN) begin
			cstage_q <= CS_IDLE;
			if (addr_pend_q) begin
				addr_q <= new_addr_q;
				addr_pend_q <= 1'b0;
			end
		end else if (state_q == ST_OUT && i_data.valid && i_data.crc_ok &&
			cstage_q == CS_STATUS_OUT) begin
			cstage_q <= CS_IDLE;
		end
	end

	// Pending report and data toggles
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			pend_q <= 1'b0;
			pchan_q <= usb_dongle_pkg::CH_KEY;
			periph_q <= 8'h00;
			plen_q <= '0;
			tog_q <= 8'h00;
		end else begin
			if (setup_take && is_set_cfg) begin
				tog_q <= 8'h00;
			end else if (ack_int) begin
				tog_q[cur_ep_q[2:0]] <= !tog_q[cur_ep_q[2:0]];
			end
			if (ack_int || (pend_q && map_ep == usb_dongle_pkg::EP_CTRL &&
				state_q == ST_IDLE)) begin
				pend_q <= 1'b0; // R14
			end else if (i_ir_commit.valid && !pend_q) begin
				pend_q <= 1'b1;
				pchan_q <= i_ir_commit.chan;
				periph_q <= i_ir_commit.periph;
				plen_q <= i_ir_commit.len;
			end
		end
	end

	// Resume signalling
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			res_cnt_q <= 32'h0;
		end else if (wake && res_cnt_q == 32'h0) begin
			res_cnt_q <= 32'(RESUME_CYCLES); // R4
		end else if (res_cnt_q != 32'h0) begin
			res_cnt_q <= res_cnt_q - 32'h1;
		end
	end

	assign o_tx = tx_q;
	assign o_ir_ready = !pend_q;
	assign o_remote_wake_ok = rwu_en_q && pwr_q; // R3
	assign o_resume = res_cnt_q != 32'h0;
	assign o_config = cfg_q;

	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);

	property p_stall;
		state_q == ST_IDLE && tok_me && i_tok.pid == usb_dongle_pkg::PID_IN &&
		i_tok.ep == usb_dongle_pkg::EP_CTRL && cstage_q == CS_STALL
		|=> o_tx.valid && o_tx.pid == usb_dongle_pkg::PID_STALL;
	endproperty
	a_stall: assert property (p_stall) else $error("no stall"); // R1
	property p_get_cfg;
		state_q == ST_IDLE && tok_me && i_tok.pid == usb_dongle_pkg::PID_IN &&
		i_tok.ep == usb_dongle_pkg::EP_CTRL && cstage_q == CS_DATA_IN
		|=> o_tx.data == {6'h00, cfg_q} && o_tx.pid == usb_dongle_pkg::PID_DATA1;
	endproperty
	a_get_cfg: assert property (p_get_cfg) else $error("bad config"); // R12
	property p_set_cfg;
		setup_take && is_set_cfg |=> o_config == $past(i_data.value[1:0]);
	endproperty
	a_set_cfg: assert property (p_set_cfg) else $error("no switch"); // R13
	property p_mapped;
		o_tx.valid && o_tx.has_data && src_int_q
		|-> map_ep != usb_dongle_pkg::EP_CTRL;
	endproperty
	a_mapped: assert property (p_mapped) else $error("unmapped data"); // R14
	property p_emul_ep;
		int_hit && cfg_q == usb_dongle_pkg::CFG_EMUL |-> i_tok.ep ==
		(pchan_q == usb_dongle_pkg::CH_KEY ? 4'h1 : 4'h5);
	endproperty
	a_emul_ep: assert property (p_emul_ep) else $error("emul ep"); // R7 R8
	property p_wake;
		wake && !o_resume |=> o_resume [*2];
	endproperty
	a_wake: assert property (p_wake) else $error("no resume"); // R4
	property p_wake_ok;
		$rose(o_resume) |-> $past(rwu_en_q) && $past(pwr_q);
	endproperty
	a_wake_ok: assert property (p_wake_ok) else $error("bad wake"); // R3
	property p_setup_first;
		$rose(state_q == ST_SETUP)
		|-> $past(i_tok.pid) == usb_dongle_pkg::PID_SETUP;
	endproperty
	a_setup_first: assert property (p_setup_first) else $error("setup"); // R11
	property p_bridge_tag;
		state_q == ST_IDLE && int_hit && pchan_q == usb_dongle_pkg::CH_BRIDGE
		|=> o_tx.data == $past(periph_q) && cur_ep_q == 4'h1 ##1 1'b1;
	endproperty
	a_bridge_tag: assert property (p_bridge_tag) else $error("tag"); // R9 R10

	c_get_cfg: cover property (setup_take && is_get_cfg);
	c_bridge: cover property (setup_take && is_set_cfg &&
		i_data.value == 8'h02);
	c_int_ack: cover property (ack_int);
	c_resume: cover property ($rose(o_resume));
endmodule

//--- include/usb_dongle_pkg.sv
// Shared constants, types and endpoint map of the dongle USB engine.
// Assumes a serial engine on the same clock that decodes packets.
package usb_dongle_pkg;

	localparam int REF_CLK_MHZ = 250;
	localparam int RESUME_US = 10;
	localparam int RESUME_CYC = RESUME_US * REF_CLK_MHZ;
	localparam int REPORT_AW = 4;

	localparam logic [3:0] PID_OUT = 4'h1;
	localparam logic [3:0] PID_IN = 4'h9;
	localparam logic [3:0] PID_SETUP = 4'hD;
	localparam logic [3:0] PID_DATA0 = 4'h3;
	localparam logic [3:0] PID_DATA1 = 4'hB;
	localparam logic [3:0] PID_ACK = 4'h2;
	localparam logic [3:0] PID_NAK = 4'hA;
	localparam logic [3:0] PID_STALL = 4'hE;

	localparam logic [3:0] EP_CTRL = 4'h0;
	localparam logic [3:0] EP_KEY = 4'h1;
	localparam logic [3:0] EP_AUX = 4'h3;
	localparam logic [3:0] EP_MOUSE = 4'h5;

	localparam logic [1:0] CFG_NONE = 2'h0;
	localparam logic [1:0] CFG_EMUL = 2'h1;
	localparam logic [1:0] CFG_BRIDGE = 2'h2;

	localparam logic [7:0] RT_DEV_OUT = 8'h00;
	localparam logic [7:0] RT_DEV_IN = 8'h80;
	localparam logic [7:0] REQ_CLR_FEATURE = 8'h01;
	localparam logic [7:0] REQ_SET_FEATURE = 8'h03;
	localparam logic [7:0] REQ_SET_ADDRESS = 8'h05;
	localparam logic [7:0] REQ_GET_CONFIG = 8'h08;
	localparam logic [7:0] REQ_SET_CONFIG = 8'h09;
	localparam logic [7:0] FEAT_RWU = 8'h01;
	localparam logic [6:0] ADDR_RESET = 7'h00;

	typedef enum logic [1:0] {CH_KEY, CH_MOUSE, CH_BRIDGE, CH_AUX} chan_type;

	typedef struct packed {
		logic valid;
		logic [3:0] pid;
		logic [6:0] addr;
		logic [3:0] ep;
	} token_type;

	typedef struct packed {
		logic valid;
		logic [3:0] pid;
		logic crc_ok;
		logic [7:0] req_type;
		logic [7:0] request;
		logic [7:0] value;
	} rx_data_type;

	typedef struct packed {
		logic valid;
		logic [3:0] pid;
		logic has_data;
		logic [7:0] data;
		logic last;
	} tx_type;

	typedef struct packed {
		logic valid;
		logic [REPORT_AW-1:0] addr;
		logic [7:0] data;
	} ir_wr_type;

	typedef struct packed {
		logic valid;
		chan_type chan;
		logic [7:0] periph;
		logic [REPORT_AW:0] len;
	} ir_commit_type;

	// Zero means the endpoint is not defined under this configuration
	function automatic logic [3:0] ep_of(chan_type ch, logic [1:0] cfg);
		logic [3:0] ep;
		ep = EP_CTRL;
		if (cfg == CFG_EMUL && ch == CH_KEY) begin
			ep = EP_KEY;
		end else if (cfg == CFG_EMUL && ch == CH_MOUSE) begin
			ep = EP_MOUSE;
		end else if (cfg == CFG_BRIDGE && ch == CH_BRIDGE) begin
			ep = EP_KEY;
		end else if (cfg == CFG_BRIDGE && ch == CH_AUX) begin
			ep = EP_AUX;
		end
		return ep;
	endfunction

endpackage

//--- sim/usb_dongle_endpoint_config_bench.sv
// Bench for the dongle USB engine: host model on the bus side,
// infrared side, suspend and supply pin driven here.
`timescale 1ns/100ps
module usb_dongle_endpoint_config_bench;
	localparam int RES_N = 20;
	logic i_ref_clk;
	logic i_rst;
	usb_dongle_pkg::token_type tok;
	usb_dongle_pkg::rx_data_type rxd;
	usb_dongle_pkg::tx_type tx;
	usb_dongle_pkg::ir_wr_type ir_wr;
	usb_dongle_pkg::ir_commit_type ir_commit;
	logic tx_ready;
	logic ir_ready;
	logic suspend;
	logic self_pwr;
	logic wake_ok;
	logic resume;
	logic [1:0] cfg;
	logic [3:0] pid;
	logic [3:0] sack;
	int bad_count = 0;
	int n_checks = 0;
	int cycles = 0;

	usb_dongle_endpoint_config #(.RESUME_CYCLES(RES_N)) dut (
		.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_tok(tok), .i_data(rxd),
		.i_tx_ready(tx_ready), .o_tx(tx), .i_ir_wr(ir_wr),
		.i_ir_commit(ir_commit), .o_ir_ready(ir_ready),
		.i_suspend(suspend), .i_self_pwr(self_pwr),
		.o_remote_wake_ok(wake_ok), .o_resume(resume), .o_config(cfg)
	);

	usb_host_model host (
		.i_ref_clk(i_ref_clk), .o_tok(tok), .o_data(rxd),
		.o_tx_ready(tx_ready), .i_tx(tx)
	);

	initial begin
		i_ref_clk = 1'b0;
		forever #2 i_ref_clk = ~i_ref_clk;
	end

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// Whole run is about a thousand cycles; a hang stops well after
	always @(posedge i_ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			wrap_up();
		end
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_pid(input logic [3:0] exp);
		chk({4'h0, pid}, {4'h0, exp});
	endtask

	// Bridge reports carry the peripheral byte first
	task automatic chk_rep(input logic [7:0] per, input int n, input int o);
		chk(8'(host.got.size()), 8'(n + o));
		if (o == 1) begin
			chk(host.got[0], per);
		end
		for (int i = 0; i < n; i++) begin
			chk(host.got[i + o], 8'hA0 + 8'(i));
		end
	endtask

	task automatic load(input usb_dongle_pkg::chan_type ch,
			input logic [7:0] per, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge i_ref_clk);
			ir_wr <= {1'b1, 4'(i), 8'hA0 + 8'(i)};
		end
		@(posedge i_ref_clk);
		ir_wr <= '0;
		ir_commit <= {1'b1, ch, per, 5'(n)};
		@(posedge i_ref_clk);
		ir_commit <= '0;
	endtask

	task automatic t_cfg1();
		chk({6'h0, cfg}, 8'h00);
		host.ctrl(usb_dongle_pkg::RT_DEV_OUT, usb_dongle_pkg::REQ_SET_CONFIG,
			8'h01, sack, pid);
		chk({4'h0, sack}, {4'h0, usb_dongle_pkg::PID_ACK});
		chk_pid(usb_dongle_pkg::PID_DATA1);
		chk({6'h0, cfg}, 8'h01);
		host.ctrl(usb_dongle_pkg::RT_DEV_IN, usb_dongle_pkg::REQ_GET_CONFIG,
			8'h00, sack, pid);
		chk(8'(host.got.size()), 8'h01);
		chk(host.got[0], 8'h01);
	endtask

	task automatic t_emul();
		load(usb_dongle_pkg::CH_KEY, 8'h00, 3);
		host.in_ep(7'h00, usb_dongle_pkg::EP_KEY, pid);
		chk_pid(usb_dongle_pkg::PID_DATA0);
		chk_rep(8'h00, 3, 0);
		@(posedge i_ref_clk);
		chk({7'h0, ir_ready}, 8'h01);
		host.slow = 3;
		load(usb_dongle_pkg::CH_MOUSE, 8'h00, 2);
		host.in_ep(7'h00, usb_dongle_pkg::EP_AUX, pid);
		chk_pid(4'h0);
		host.in_ep(7'h00, usb_dongle_pkg::EP_MOUSE, pid);
		chk_pid(usb_dongle_pkg::PID_DATA0);
		chk_rep(8'h00, 2, 0);
		host.slow = 0;
	endtask

	task automatic t_bridge();
		host.ctrl(usb_dongle_pkg::RT_DEV_OUT, usb_dongle_pkg::REQ_SET_CONFIG,
			8'h02, sack, pid);
		chk({6'h0, cfg}, 8'h02);
		load(usb_dongle_pkg::CH_BRIDGE, 8'hA0, 2);
		host.in_ep(7'h00, usb_dongle_pkg::EP_KEY, pid);
		chk_pid(usb_dongle_pkg::PID_DATA0);
		chk_rep(8'hA0, 2, 1);
		load(usb_dongle_pkg::CH_KEY, 8'h00, 1);
		repeat (20) @(posedge i_ref_clk);
		chk({7'h0, ir_ready}, 8'h01);
	endtask

	task automatic t_wake();
		int n;
		self_pwr <= 1'b1;
		host.ctrl(usb_dongle_pkg::RT_DEV_OUT, usb_dongle_pkg::REQ_SET_FEATURE,
			usb_dongle_pkg::FEAT_RWU, sack, pid);
		repeat (4) @(posedge i_ref_clk);
		chk({7'h0, wake_ok}, 8'h01);
		self_pwr <= 1'b0;
		repeat (5) @(posedge i_ref_clk);
		chk({7'h0, wake_ok}, 8'h00);
		self_pwr <= 1'b1;
		suspend <= 1'b1;
		repeat (5) @(posedge i_ref_clk);
		load(usb_dongle_pkg::CH_BRIDGE, 8'h02, 1);
		for (int k = 0; k < 40 && resume !== 1'b1; k++) begin
			@(posedge i_ref_clk);
		end
		n = 0;
		while (resume === 1'b1 && n < 100) begin
			@(posedge i_ref_clk);
			n++;
		end
		chk(8'(n), 8'(RES_N));
		suspend <= 1'b0;
		host.in_ep(7'h00, usb_dongle_pkg::EP_KEY, pid);
		chk_pid(usb_dongle_pkg::PID_DATA1);
		host.ctrl(usb_dongle_pkg::RT_DEV_OUT, usb_dongle_pkg::REQ_CLR_FEATURE,
			usb_dongle_pkg::FEAT_RWU, sack, pid);
		chk({7'h0, wake_ok}, 8'h00);
		suspend <= 1'b1;
		load(usb_dongle_pkg::CH_BRIDGE, 8'h03, 1);
		n = 0;
		repeat (40) begin
			@(posedge i_ref_clk);
			n += (resume === 1'b1) ? 1 : 0;
		end
		chk(8'(n), 8'h00);
		suspend <= 1'b0;
		host.in_ep(7'h00, usb_dongle_pkg::EP_KEY, pid);
	endtask

	task automatic t_refuse();
		host.ctrl(usb_dongle_pkg::RT_DEV_OUT, 8'h0B, 8'h00, sack, pid);
		chk({4'h0, sack}, {4'h0, usb_dongle_pkg::PID_ACK});
		chk_pid(usb_dongle_pkg::PID_STALL);
		host.in_ep(7'h11, usb_dongle_pkg::EP_KEY, pid);
		chk_pid(4'h0);
		host.in_ep(7'h00, 4'h2, pid);
		chk_pid(4'h0);
		host.tok(usb_dongle_pkg::PID_SETUP, 7'h00, usb_dongle_pkg::EP_CTRL);
		host.dat(usb_dongle_pkg::PID_DATA0, 8'h80, 8'h08, 8'h00, 1'b0);
		host.resp(pid);
		chk_pid(4'h0);
		// Address moves only after the status stage, so ctrl ends here
		host.ctrl(usb_dongle_pkg::RT_DEV_OUT, usb_dongle_pkg::REQ_SET_ADDRESS,
			8'h11, sack, pid);
		chk_pid(usb_dongle_pkg::PID_DATA1);
		host.in_ep(7'h11, usb_dongle_pkg::EP_KEY, pid);
		chk_pid(usb_dongle_pkg::PID_NAK);
		host.in_ep(7'h00, usb_dongle_pkg::EP_KEY, pid);
		chk_pid(4'h0);
	endtask

	initial begin
		i_rst = 1'b1;
		ir_wr = '0;
		ir_commit = '0;
		suspend = 1'b0;
		self_pwr = 1'b0;
		repeat (10) @(posedge i_ref_clk);
		i_rst <= 1'b0;
		@(posedge i_ref_clk);
		chk({7'h0, tx.valid}, 8'h00);
		chk({7'h0, ir_ready}, 8'h01);
		t_cfg1();
		t_emul();
		t_bridge();
		t_wake();
		t_refuse();
		wrap_up();
	end
endmodule

//--- sim/usb_host_model.sv
// Host controller model: sends tokens and data packets, takes replies.
// Assumes the bench calls its tasks, one transfer at a time.
`timescale 1ns/100ps
module usb_host_model (
	input wire logic i_ref_clk,
	output usb_dongle_pkg::token_type o_tok,
	output usb_dongle_pkg::rx_data_type o_data,
	output logic o_tx_ready,
	input wire usb_dongle_pkg::tx_type i_tx
);
	logic [7:0] got[$];
	int slow = 0;

	initial begin
		o_tok = '0;
		o_data = '0;
		o_tx_ready = 1'b0;
	end

	// Idle fields inverted so a stale packet never reads as fresh
	task automatic tok(input logic [3:0] pid, input logic [6:0] addr,
			input logic [3:0] ep);
		@(posedge i_ref_clk);
		o_tok <= {1'b1, pid, addr, ep};
		@(posedge i_ref_clk);
		o_tok <= {1'b0, ~pid, ~addr, ~ep};
	endtask

	task automatic dat(input logic [3:0] pid, input logic [7:0] rt,
			input logic [7:0] rq, input logic [7:0] val, input logic crc);
		@(posedge i_ref_clk);
		o_data <= {1'b1, pid, crc, rt, rq, val};
		@(posedge i_ref_clk);
		o_data <= {1'b0, ~pid, ~crc, ~rt, ~rq, ~val};
	endtask

	// Zero pid means no answer; slow holds off ready to stall the device
	task automatic resp(output logic [3:0] pid);
		int w;
		logic first;
		pid = 4'h0;
		w = 0;
		first = 1'b1;
		got.delete();
		for (int k = 0; k < 80; k++) begin
			@(posedge i_ref_clk);
			if (o_tx_ready && i_tx.valid) begin
				if (first) begin
					pid = i_tx.pid;
				end
				first = 1'b0;
				if (i_tx.has_data) begin
					got.push_back(i_tx.data);
				end
				o_tx_ready <= 1'b0;
				w = 0;
				if (i_tx.last) begin
					break;
				end
			end else if (i_tx.valid) begin
				w++;
				o_tx_ready <= (w > slow);
			end
		end
	endtask

	task automatic in_ep(input logic [6:0] addr, input logic [3:0] ep,
			output logic [3:0] pid);
		tok(usb_dongle_pkg::PID_IN, addr, ep);
		resp(pid);
		if (pid == usb_dongle_pkg::PID_DATA0 ||
				pid == usb_dongle_pkg::PID_DATA1) begin
			tok(usb_dongle_pkg::PID_ACK, addr, ep);
		end
	endtask

	// Every control transfer opens with a setup stage
	task automatic ctrl(input logic [7:0] rt, input logic [7:0] rq,
			input logic [7:0] val, output logic [3:0] sack,
			output logic [3:0] pid);
		logic [3:0] st;
		logic [7:0] keep[$];
		tok(usb_dongle_pkg::PID_SETUP, 7'h00, usb_dongle_pkg::EP_CTRL);
		dat(usb_dongle_pkg::PID_DATA0, rt, rq, val, 1'b1);
		resp(sack);
		in_ep(7'h00, usb_dongle_pkg::EP_CTRL, pid);
		keep = got;
		if (rt[7] && pid != usb_dongle_pkg::PID_STALL) begin
			tok(usb_dongle_pkg::PID_OUT, 7'h00, usb_dongle_pkg::EP_CTRL);
			dat(usb_dongle_pkg::PID_DATA1, 8'h00, 8'h00, 8'h00, 1'b1);
			resp(st);
		end
		got = keep;
	endtask
endmodule
